// ### common/ictl_pkg.sv
// Constants shared by the prioritised interrupt controller.
package ictl_pkg;
    localparam int          NUM_SRC       = 41;
    localparam int          NUM_TRAP      = 4;
    localparam int          NUM_PRIO_REGS = 11;
    localparam int          NUM_VECTORS   = 63;
    // Register byte offsets on the APB port.
    localparam logic [11:0] OFS_FLAGS0    = 12'h000;
    localparam logic [11:0] OFS_FLAGS1    = 12'h004;
    localparam logic [11:0] OFS_FLAGS2    = 12'h008;
    localparam logic [11:0] OFS_EN0       = 12'h00C;
    localparam logic [11:0] OFS_EN1       = 12'h010;
    localparam logic [11:0] OFS_EN2       = 12'h014;
    localparam logic [11:0] OFS_PRIO0     = 12'h018;
    localparam logic [11:0] OFS_PRIO10    = 12'h040;
    localparam logic [11:0] OFS_EXC_CTRL  = 12'h044;
    localparam logic [11:0] OFS_EXT_CTRL  = 12'h048;
    localparam logic [11:0] OFS_PEND_VEC  = 12'h04C;
    localparam logic [11:0] OFS_CORE_CTRL = 12'h050;
    localparam logic [11:0] OFS_CORE_STAT = 12'h054;
    localparam logic [11:0] OFS_TIMED_INTERRUPT_DISABLE_CNT  = 12'h058;
    // Field positions.
    localparam int          NEST_BIT      = 15;
    localparam int          TIMED_INTERRUPT_DISABLE_BIT      = 14;
    localparam int          ALT_BIT       = 15;
    localparam int          EXT0_POL_BIT  = 0;
    localparam int          IPL3_BIT      = 3;
    localparam int          IPL_LO_POS    = 5;
    localparam int          VECTOR_NUMBER_FIELD_POS    = 0;
    localparam int          ILR_POS       = 8;
    localparam int          ADDR_ERR_TRAP = 1;
    // Reset values.
    localparam logic [2:0]  PRIO_RST      = 3'h4;
    localparam logic [3:0]  CPU_LVL_RST   = 4'h0;
    // Vector numbering and levels.
    localparam logic [5:0]  VEC_SRC_BASE  = 6'h08;
    localparam logic [5:0]  VEC_TRAP_BASE = 6'h01;
    localparam logic [3:0]  TRAP_LVL      = 4'h8;
    localparam logic [3:0]  TIMED_INTERRUPT_DISABLE_MAX_LVL  = 4'h6;
    // Program memory vector space.
    localparam logic [23:0] IVT_BASE      = 24'h000004;
    localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE     = 24'h000084;
    localparam logic [23:0] VEC_SPACE_LO  = 24'h000004;
    localparam logic [23:0] VEC_SPACE_HI  = 24'h0000FE;
endpackage : ictl_pkg

// ### hw/ictl_top.sv
// Prioritised interrupt controller with APB register slave.
`timescale 1ns/100ps
module ictl_top #(
    parameter int STACK_DEPTH = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [40:0] periph_irq,
    input  wire logic        ext_req_zero,
    input  wire logic [3:0]  trap_req,
    input  wire logic        irq_ack,
    input  wire logic        irq_ret,
    input  wire logic        instr_retire,
    input  wire logic        fetch_valid,
    input  wire logic [23:0] fetch_addr,
    input  wire logic [23:0] seq_pc,
    input  wire logic [23:0] vec_word,
    input  wire logic        vec_word_valid,
    output logic             irq_req,
    output logic      [5:0]  irq_vector,
    output logic      [3:0]  irq_level,
    output logic             vec_rd,
    output logic      [23:0] vec_addr,
    output logic             pc_load,
    output logic      [23:0] pc_value,
    output logic             addr_err_trap,
    output logic      [3:0]  cpu_priority_level
);
    localparam int DW = $clog2(STACK_DEPTH + 1);

    typedef struct packed {
        logic [47:0]                  flags;
        logic [47:0]                  en;
        logic [43:0][2:0]             prio;
        logic                         nest;
        logic [3:0]                   trapf;
        logic                         alt;
        logic                         ext_pol;
        logic [13:0]                  timed_interrupt_disable_cnt;
        logic [3:0]                   cpu_lvl;
        logic [STACK_DEPTH-1:0][3:0]  stk;
        logic [DW-1:0]                depth;
        logic [5:0]                   pend_vec;
        logic [3:0]                   pend_lvl;
        logic                         req;
        logic                         ext_s1;
        logic                         ext_s2;
        logic                         ext_s3;
        logic                         vec_rd;
        logic [23:0]                  vec_addr;
        logic                         pc_load;
        logic [23:0]                  pc_val;
        logic                         addr_err;
    } ictl_state_type;

    ictl_state_type s_r;
    ictl_state_type s_nxt;

    logic        apb_wr;
    logic        apb_rd;
    logic        prio_hit;
    logic [11:0] prio_ofs;
    logic [3:0]  prio_k;
    logic [47:0] src_set;
    logic [3:0]  trap_set;
    logic        ext_edge;
    logic        in_service;
    logic        ack_take;
    logic        win_valid;
    logic        win_trap;
    logic [5:0]  win_idx;
    logic [5:0]  win_vec;
    logic [3:0]  win_lvl;

    // Returns one priority register word, one source per nibble.
    function automatic logic [15:0] prio_word(input logic [43:0][2:0] p, input logic [3:0] k);
        logic [15:0] w;
        w = 16'h0000;
        for (int j = 0; j < 4; j++)
        begin
            w[4*j +: 3] = ((4 * int'(k) + j) < ictl_pkg::NUM_SRC) ? p[4*k + j] : 3'h0;
        end
        return w;
    endfunction : prio_word

    // Software write of a 16-bit flag word; a hardware set in the same cycle wins.
    function automatic logic [15:0] flag_upd(input logic [15:0] old, input logic wr,
                                             input logic [15:0] wd, input logic [15:0] set);
        return (wr ? wd : old) | set;
    endfunction : flag_upd

    assign apb_wr     = psel & penable & pwrite;
    assign apb_rd     = psel & penable & ~pwrite;
    assign prio_ofs   = paddr - ictl_pkg::OFS_PRIO0;
    assign prio_k     = prio_ofs[5:2];
    assign prio_hit   = (paddr >= ictl_pkg::OFS_PRIO0) && (paddr <= ictl_pkg::OFS_PRIO10)
                        && (paddr[1:0] == 2'b00);
    assign in_service = (s_r.depth != '0);
    assign ack_take   = irq_ack & s_r.req;
    // External pin edge, polarity chosen by software; reads only settled sync stages.
    assign ext_edge   = s_r.ext_pol ? (~s_r.ext_s2 & s_r.ext_s3)
                                    : (s_r.ext_s2 & ~s_r.ext_s3);
    // Peripherals deliver already qualified requests; triggering lives there.
    assign src_set    = {7'h00, periph_irq} | {47'h0, ext_edge};
    assign trap_set   = trap_req | {2'b00, s_r.addr_err, 1'b0};

    // Arbitration: traps first, then highest user level, ties to lowest number.
    always_comb
    begin
        logic [3:0] lvl;
        logic       ok;
        lvl       = 4'h0;
        ok        = 1'b0;
        win_valid = 1'b0;
        win_trap  = 1'b0;
        win_idx   = 6'h00;
        win_lvl   = 4'h0;
        for (int i = 0; i < ictl_pkg::NUM_TRAP; i++)
        begin
            if (!win_valid && s_r.trapf[i] && (ictl_pkg::TRAP_LVL > s_r.cpu_lvl))
            begin
                win_valid = 1'b1;
                win_trap  = 1'b1;
                win_idx   = 6'(i);
                win_lvl   = ictl_pkg::TRAP_LVL;
            end
        end
        for (int i = 0; i < ictl_pkg::NUM_SRC; i++)
        begin
            lvl = {1'b0, s_r.prio[i]};
            ok  = s_r.flags[i] && s_r.en[i]
                  && (lvl != 4'h0)
                  && (lvl > s_r.cpu_lvl)
                  && !(s_r.nest && in_service)
                  && !((s_r.timed_interrupt_disable_cnt != 14'h0) && (lvl <= ictl_pkg::TIMED_INTERRUPT_DISABLE_MAX_LVL));
            // Strict compare keeps the lowest number on equal levels.
            if (ok && !win_trap && (!win_valid || (lvl > win_lvl)))
            begin
                win_valid = 1'b1;
                win_idx   = 6'(i);
                win_lvl   = lvl;
            end
        end
        win_vec = win_trap ? (ictl_pkg::VEC_TRAP_BASE + win_idx)
                           : (ictl_pkg::VEC_SRC_BASE + win_idx);
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ext_s1 = ext_req_zero;
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.ext_s3 = s_r.ext_s2;
        // Register writes.
        if (apb_wr)
        begin
            if (prio_hit)
            begin
                for (int j = 0; j < 4; j++)
                begin
                    if ((4 * int'(prio_k) + j) < ictl_pkg::NUM_SRC)
                    begin
                        s_nxt.prio[4*prio_k + j] = pwdata[4*j +: 3];
                    end
                end
            end
            else if (paddr == ictl_pkg::OFS_EN0)
            begin
                s_nxt.en[15:0] = pwdata[15:0];
            end
            else if (paddr == ictl_pkg::OFS_EN1)
            begin
                s_nxt.en[31:16] = pwdata[15:0];
            end
            else if (paddr == ictl_pkg::OFS_EN2)
            begin
                s_nxt.en[47:32] = {7'h00, pwdata[8:0]};
            end
            else if (paddr == ictl_pkg::OFS_EXC_CTRL)
            begin
                s_nxt.nest  = pwdata[ictl_pkg::NEST_BIT];
                s_nxt.trapf = pwdata[3:0];
            end
            else if (paddr == ictl_pkg::OFS_EXT_CTRL)
            begin
                s_nxt.alt     = pwdata[ictl_pkg::ALT_BIT];
                s_nxt.ext_pol = pwdata[ictl_pkg::EXT0_POL_BIT];
            end
            else if ((paddr == ictl_pkg::OFS_CORE_CTRL) && !s_r.nest)
            begin
                s_nxt.cpu_lvl[3] = pwdata[ictl_pkg::IPL3_BIT];
            end
            else if ((paddr == ictl_pkg::OFS_CORE_STAT) && !s_r.nest)
            begin
                s_nxt.cpu_lvl[2:0] = pwdata[ictl_pkg::IPL_LO_POS +: 3];
            end
        end
        s_nxt.flags[15:0]  = flag_upd(s_r.flags[15:0], apb_wr && (paddr == ictl_pkg::OFS_FLAGS0),
                                      pwdata[15:0], src_set[15:0]);
        s_nxt.flags[31:16] = flag_upd(s_r.flags[31:16], apb_wr && (paddr == ictl_pkg::OFS_FLAGS1),
                                      pwdata[15:0], src_set[31:16]);
        s_nxt.flags[47:32] = flag_upd(s_r.flags[47:32], apb_wr && (paddr == ictl_pkg::OFS_FLAGS2),
                                      {7'h00, pwdata[8:0]}, src_set[47:32]);
        s_nxt.trapf = s_nxt.trapf | trap_set;
        // Timed disable counts retired instructions down to zero.
        if (apb_wr && (paddr == ictl_pkg::OFS_TIMED_INTERRUPT_DISABLE_CNT))
        begin
            s_nxt.timed_interrupt_disable_cnt = pwdata[13:0];
        end
        else if (instr_retire && (s_r.timed_interrupt_disable_cnt != 14'h0))
        begin
            s_nxt.timed_interrupt_disable_cnt = s_r.timed_interrupt_disable_cnt - 14'h1;
        end
        s_nxt.req = win_valid;
        if (win_valid)
        begin
            s_nxt.pend_vec = win_vec;
            s_nxt.pend_lvl = win_lvl;
        end
        // Acceptance raises the CPU level; return restores the saved one.
        s_nxt.vec_rd = ack_take;
        if (ack_take)
        begin
            if (s_r.depth != DW'(STACK_DEPTH))
            begin
                s_nxt.stk[s_r.depth] = s_r.cpu_lvl;
                s_nxt.depth          = s_r.depth + DW'(1);
            end
            s_nxt.cpu_lvl  = s_r.pend_lvl;
            s_nxt.vec_addr = (s_r.alt ? ictl_pkg::ALTERNATE_VECTOR_TABLE_BASE : ictl_pkg::IVT_BASE)
                             + {17'h0, s_r.pend_vec, 1'b0};
        end
        else if (irq_ret && in_service)
        begin
            s_nxt.depth   = s_r.depth - DW'(1);
            s_nxt.cpu_lvl = s_r.stk[s_r.depth - DW'(1)];
        end
        s_nxt.pc_load = vec_word_valid;
        s_nxt.pc_val  = vec_word_valid ? vec_word : seq_pc;
        s_nxt.addr_err = fetch_valid && (fetch_addr >= ictl_pkg::VEC_SPACE_LO)
                         && (fetch_addr <= ictl_pkg::VEC_SPACE_HI);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r         <= '0;
            s_r.prio    <= {44{ictl_pkg::PRIO_RST}};
            s_r.cpu_lvl <= ictl_pkg::CPU_LVL_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Read decode; registers answer in the first access cycle.
    always_comb
    begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (prio_hit)
        begin
            prdata[15:0] = prio_word(s_r.prio, prio_k);
        end
        else if ((paddr <= ictl_pkg::OFS_EN2) && (paddr[1:0] == 2'b00))
        begin
            prdata[15:0] = 16'({s_r.en, s_r.flags} >> (16 * paddr[4:2]));
        end
        else if (paddr == ictl_pkg::OFS_EXC_CTRL)
        begin
            prdata[ictl_pkg::NEST_BIT] = s_r.nest;
            prdata[3:0]                = s_r.trapf;
        end
        else if (paddr == ictl_pkg::OFS_EXT_CTRL)
        begin
            prdata[ictl_pkg::ALT_BIT]      = s_r.alt;
            prdata[ictl_pkg::TIMED_INTERRUPT_DISABLE_BIT]     = (s_r.timed_interrupt_disable_cnt != 14'h0);
            prdata[ictl_pkg::EXT0_POL_BIT] = s_r.ext_pol;
        end
        else if (paddr == ictl_pkg::OFS_PEND_VEC)
        begin
            prdata[ictl_pkg::VECTOR_NUMBER_FIELD_POS +: 6] = s_r.pend_vec;
            prdata[ictl_pkg::ILR_POS +: 4]    = s_r.pend_lvl;
        end
        else if (paddr == ictl_pkg::OFS_CORE_CTRL)
        begin
            prdata[ictl_pkg::IPL3_BIT] = s_r.cpu_lvl[3];
        end
        else if (paddr == ictl_pkg::OFS_CORE_STAT)
        begin
            prdata[ictl_pkg::IPL_LO_POS +: 3] = s_r.cpu_lvl[2:0];
        end
        else if (paddr == ictl_pkg::OFS_TIMED_INTERRUPT_DISABLE_CNT)
        begin
            prdata[13:0] = s_r.timed_interrupt_disable_cnt;
        end
        else
        begin
            pslverr = psel & penable;
        end
        if (!apb_rd)
        begin
            prdata = 32'h0000_0000;
        end
    end

    assign pready             = 1'b1;
    assign irq_req            = s_r.req;
    assign irq_vector         = s_r.pend_vec;
    assign irq_level          = s_r.pend_lvl;
    assign vec_rd             = s_r.vec_rd;
    assign vec_addr           = s_r.vec_addr;
    assign pc_load            = s_r.pc_load;
    assign pc_value           = s_r.pc_val;
    assign addr_err_trap      = s_r.addr_err;
    assign cpu_priority_level = s_r.cpu_lvl;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_flag_set;
        (src_set != 48'h0) |=> ((s_r.flags & $past(src_set)) == $past(src_set));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Request flag not set");
    property p_enable_gate;
        (win_valid && !win_trap) |-> s_r.en[win_idx];
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("Disabled source won");
    property p_zero_prio;
        (win_valid && !win_trap) |-> (s_r.prio[win_idx] != 3'h0);
    endproperty
    a_zero_prio: assert property (p_zero_prio) else $error("Level zero source won");
    property p_above_cpu;
        win_valid |-> (win_lvl > s_r.cpu_lvl);
    endproperty
    a_above_cpu: assert property (p_above_cpu) else $error("Winner not above CPU level");
    property p_nest_block;
        (s_r.nest && in_service && win_valid) |-> win_trap;
    endproperty
    a_nest_block: assert property (p_nest_block) else $error("Nested while disabled");
    property p_ipl_ro;
        (apb_wr && s_r.nest && !ack_take && !irq_ret) |=> $stable(s_r.cpu_lvl);
    endproperty
    a_ipl_ro: assert property (p_ipl_ro) else $error("CPU level written under nest");
    property p_timed_interrupt_disable;
        ((s_r.timed_interrupt_disable_cnt != 14'h0) && win_valid && !win_trap) |-> (win_lvl == 4'h7);
    endproperty
    a_timed_interrupt_disable: assert property (p_timed_interrupt_disable) else $error("Low level passed timed disable");
    property p_latch;
        win_valid |=> (s_r.pend_vec == $past(win_vec)) && (s_r.pend_lvl == $past(win_lvl)) && irq_req;
    endproperty
    a_latch: assert property (p_latch) else $error("Pending vector not latched");
    property p_addr_err;
        (fetch_valid && (fetch_addr >= 24'h000004) && (fetch_addr <= 24'h0000FE))
            |=> addr_err_trap ##1 s_r.trapf[1];
    endproperty
    a_addr_err: assert property (p_addr_err) else $error("Vector fetch not trapped");
endmodule : ictl_top

// ### verif/ictl_core_model.sv
// Behavioural processor core that takes interrupts and fetches vector words.
`timescale 1ns/100ps
module ictl_core_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ack_en,
    input  wire logic [3:0]  fetch_delay,
    input  wire logic        ret_go,
    input  wire logic        irq_req,
    input  wire logic        vec_rd,
    input  wire logic [23:0] vec_addr,
    output logic             irq_ack,
    output logic             irq_ret,
    output logic      [23:0] vec_word,
    output logic             vec_word_valid
);
    int          wait_cnt;
    logic        busy;
    logic [23:0] addr_r;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_ack        <= 1'b0;
            irq_ret        <= 1'b0;
            vec_word       <= 24'h5A5A5A;
            vec_word_valid <= 1'b0;
            wait_cnt       <= -1;
            busy           <= 1'b0;
            addr_r         <= 24'h000000;
        end
        else
        begin
            irq_ack        <= 1'b0;
            irq_ret        <= ret_go;
            vec_word_valid <= 1'b0;
            vec_word       <= ~vec_word;
            if (ack_en && irq_req && !busy)
            begin
                irq_ack <= 1'b1;
                busy    <= 1'b1;
            end
            if (vec_rd)
            begin
                addr_r   <= vec_addr;
                wait_cnt <= int'(fetch_delay);
            end
            else if (wait_cnt == 0)
            begin
                vec_word_valid <= 1'b1;
                vec_word       <= addr_r ^ 24'hC30000;
                busy           <= 1'b0;
                wait_cnt       <= -1;
            end
            else if (wait_cnt > 0)
                wait_cnt <= wait_cnt - 1;
        end
    end
endmodule : ictl_core_model

// ### verif/ictl_top_test.sv
// Self-checking bench for the prioritised interrupt controller.
`timescale 1ns/100ps
module ictl_top_test;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [40:0] periph_irq = '0;
    logic        ext_req_zero = 1'b0;
    logic [3:0]  trap_req = 4'h0;
    logic        instr_retire = 1'b0;
    logic        fetch_valid = 1'b0;
    logic [23:0] fetch_addr = 24'h000200;
    logic [23:0] seq_pc = 24'h000200;
    logic        ack_en = 1'b0;
    logic [3:0]  fetch_delay = 4'h0;
    logic        ret_go = 1'b0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, e, irq_ack, irq_ret, vec_word_valid, irq_req;
    logic        vec_rd, pc_load, addr_err_trap;
    logic [23:0] vec_word, vec_addr, pc_value;
    logic [5:0]  irq_vector;
    logic [3:0]  irq_level, cpu_priority_level;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          pr[41], en[41], fl[41], lvl, w, alt;
    int          stk[$];
    int          fa[4] = '{4, 254, 2, 256};

    ictl_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_irq(periph_irq),
        .ext_req_zero(ext_req_zero), .trap_req(trap_req), .irq_ack(irq_ack),
        .irq_ret(irq_ret), .instr_retire(instr_retire), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .seq_pc(seq_pc), .vec_word(vec_word),
        .vec_word_valid(vec_word_valid), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_level(irq_level), .vec_rd(vec_rd), .vec_addr(vec_addr), .pc_load(pc_load),
        .pc_value(pc_value), .addr_err_trap(addr_err_trap),
        .cpu_priority_level(cpu_priority_level));
    ictl_core_model u_core (.sys_clk(sys_clk), .rst_n(rst_n), .ack_en(ack_en),
        .fetch_delay(fetch_delay), .ret_go(ret_go), .irq_req(irq_req), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .irq_ack(irq_ack), .irq_ret(irq_ret), .vec_word(vec_word),
        .vec_word_valid(vec_word_valid));

    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        seq_pc <= 24'($urandom);
        cyc    <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(negedge sys_clk);
        while (pready !== 1'b1)
            @(negedge sys_clk);
        q = prdata;
        e = pslverr;
        @(posedge sys_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex,
                       input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(nm, ex & m, q & m);
    endtask : rdc

    // Packs flag or enable bits (p = 0) or priority nibbles (p = 1) of register r.
    function automatic logic [31:0] pk(input int a[41], input int r, input int p);
        logic [31:0] v;
        int          i;
        v = 32'h0;
        for (int b = 0; b < (p ? 4 : 16); b++)
        begin
            i = (p ? 4 : 16) * r + b;
            if (i < 41)
                v = v | (32'(p ? a[i] % 8 : a[i] % 2) << (p ? 4 * b : b));
        end
        return v;
    endfunction : pk

    function automatic int win(input int t);
        int b;
        b = -1;
        for (int i = 0; i < 41; i++)
            if (fl[i] != 0 && en[i] != 0 && pr[i] > t && (b < 0 || pr[i] > pr[b]))
                b = i;
        return b;
    endfunction : win

    task automatic load();
        for (int r = 0; r < 3; r++)
        begin
            wfl(r);
            apb(1'b1, ictl_pkg::OFS_EN0 + 12'(4 * r), pk(en, r, 0));
        end
        for (int r = 0; r < 11; r++)
            apb(1'b1, ictl_pkg::OFS_PRIO0 + 12'(4 * r), pk(pr, r, 1));
        apb(1'b1, ictl_pkg::OFS_CORE_STAT, 32'(lvl % 8) << 5);
        apb(1'b1, ictl_pkg::OFS_CORE_CTRL, 32'(lvl / 8) << 3);
    endtask : load

    task automatic wfl(input int r);
        apb(1'b1, ictl_pkg::OFS_FLAGS0 + 12'(4 * r), pk(fl, r, 0));
    endtask : wfl

    task automatic pres(input int t);
        int b;
        repeat (3) @(posedge sys_clk);
        #1;
        b = win(t);
        chk("irq_req", 32'(b >= 0), 32'(irq_req));
        if (b >= 0)
        begin
            chk("irq_vector", 32'(8 + b), 32'(irq_vector));
            chk("irq_level", 32'(pr[b]), 32'(irq_level));
        end
    endtask : pres

    task automatic svc(input int s, input int a);
        int va;
        va = int'(a ? ictl_pkg::ALTERNATE_VECTOR_TABLE_BASE : ictl_pkg::IVT_BASE) + 2 * (8 + s);
        ack_en      <= 1'b1;
        fetch_delay <= 4'($urandom % 8);
        do
            @(posedge sys_clk) #1;
        while (vec_rd !== 1'b1);
        ack_en <= 1'b0;
        chk("vec_addr", 32'(va), 32'(vec_addr));
        chk("cpu_level", 32'(pr[s]), 32'(cpu_priority_level));
        do
            @(posedge sys_clk) #1;
        while (pc_load !== 1'b1);
        chk("pc_value", 32'(va) ^ 32'hC30000, 32'(pc_value));
        stk.push_back(lvl);
        lvl = pr[s];
    endtask : svc

    task automatic ret();
        ret_go <= 1'b1;
        @(posedge sys_clk);
        ret_go <= 1'b0;
        lvl = stk.pop_back();
        repeat (3) @(posedge sys_clk);
        #1;
        chk("cpu_level", 32'(lvl), 32'(cpu_priority_level));
    endtask : ret

    initial
    begin
        void'($urandom(32'h48FE1047));
        pr = '{default: 4};
        lvl = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 11; r++)
        begin
            rdc("priority_cfg", ictl_pkg::OFS_PRIO0 + 12'(4 * r), pk(pr, r, 1), '1);
            apb(1'b1, ictl_pkg::OFS_PRIO0 + 12'(4 * r), $urandom);
            for (int n = 0; n < 4 && 4 * r + n < 41; n++)
                pr[4 * r + n] = int'(pwdata[4 * n +: 3]);
            rdc("priority_cfg", ictl_pkg::OFS_PRIO0 + 12'(4 * r), pk(pr, r, 1), '1);
        end
        chk("cpu_level", 32'h0, 32'(cpu_priority_level));
        for (int k = 0; k < 4; k++)
        begin
            w = 1 + $urandom % 40;
            periph_irq <= 41'h1 << w;
            @(posedge sys_clk);
            periph_irq <= '0;
            fl[w] = 1;
            rdc("irq_flags", ictl_pkg::OFS_FLAGS0 + 12'(4 * (w / 16)), pk(fl, w / 16, 0),
                32'hFFFF);
        end
        ext_req_zero <= 1'b1;
        fl[0] = 1;
        repeat (5) @(posedge sys_clk);
        rdc("irq_flags", ictl_pkg::OFS_FLAGS0, pk(fl, 0, 0), 32'hFFFF);
        pres(lvl);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("pslverr", 32'h1, 32'(e));
        for (int it = 0; it < 16; it++)
        begin
            for (int i = 0; i < 41; i++)
            begin
                pr[i] = $urandom % 8;
                en[i] = $urandom % 2;
                fl[i] = ($urandom % 3) == 0;
            end
            lvl = $urandom % 8;
            alt = $urandom % 2;
            apb(1'b1, ictl_pkg::OFS_EXT_CTRL, 32'(alt) << 15);
            load();
            pres(lvl);
            w = win(lvl);
            if (w >= 0)
            begin
                rdc("pending_vector", ictl_pkg::OFS_PEND_VEC, (32'(pr[w]) << 8) | 32'(8 + w),
                    32'hF3F);
                svc(w, alt);
                fl[w] = 0;
                wfl(w / 16);
                pres(lvl);
                ret();
            end
        end
        fl = '{default: 0};
        en = '{default: 1};
        pr = '{default: 0};
        pr[5] = 3;
        fl[5] = 1;
        pr[30] = 7;
        lvl = 0;
        apb(1'b1, ictl_pkg::OFS_EXT_CTRL, 32'h0);
        load();
        apb(1'b1, ictl_pkg::OFS_EXC_CTRL, 32'h8000);
        svc(5, 0);
        fl[30] = 1;
        wfl(1);
        pres(7);
        apb(1'b1, ictl_pkg::OFS_CORE_STAT, 32'h0);
        rdc("core_status", ictl_pkg::OFS_CORE_STAT, 32'h60, 32'hE0);
        ret();
        pres(lvl);
        apb(1'b1, ictl_pkg::OFS_EXC_CTRL, 32'h0);
        lvl = 8;
        apb(1'b1, ictl_pkg::OFS_CORE_CTRL, 32'h8);
        apb(1'b1, ictl_pkg::OFS_CORE_STAT, 32'h0);
        pres(lvl);
        chk("cpu_level", 32'h8, 32'(cpu_priority_level));
        lvl = 0;
        fl[5] = 0;
        fl[30] = 0;
        pr[12] = 6;
        fl[12] = 1;
        pr[20] = 7;
        load();
        apb(1'b1, ictl_pkg::OFS_TIMED_INTERRUPT_DISABLE_CNT, 32'h3);
        rdc("ext_table_ctrl", ictl_pkg::OFS_EXT_CTRL, 32'h4000, 32'h4000);
        pres(6);
        fl[20] = 1;
        wfl(1);
        pres(6);
        fl[20] = 0;
        wfl(1);
        repeat (3)
        begin
            instr_retire <= 1'b1;
            @(posedge sys_clk);
            instr_retire <= 1'b0;
            @(posedge sys_clk);
        end
        rdc("ext_table_ctrl", ictl_pkg::OFS_EXT_CTRL, 32'h0, 32'h4000);
        pres(lvl);
        for (int k = 0; k < 4; k++)
        begin
            alt = fa[k] >= 4 && fa[k] <= 254;
            fetch_valid <= 1'b1;
            fetch_addr  <= 24'(fa[k]);
            @(posedge sys_clk);
            fetch_valid <= 1'b0;
            #1;
            chk("addr_err_trap", 32'(alt), 32'(addr_err_trap));
            rdc("exc_ctrl", ictl_pkg::OFS_EXC_CTRL, 32'(alt) << 1, 32'h2);
            if (alt != 0)
                chk("irq_vector", 32'h2, 32'(irq_vector));
            apb(1'b1, ictl_pkg::OFS_EXC_CTRL, 32'h0);
        end
        report_and_stop();
    end
endmodule : ictl_top_test
